// ===== rtl/empc_config_regs.sv
// Metering configuration bank: pulse routing, metering modes, meter enables
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "empc_defs.svh"
module empc_config_regs #(
  parameter int ADDR_W = 8,
  parameter int PHASES = 3
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic [ADDR_W-1:0]      regAddr,
  input  wire empc_pkg::empc_word_t   regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output empc_pkg::empc_word_t        regRdData,
  input  wire logic                   wiringModeSel,
  input  wire empc_pkg::empc_energy_t energyPulse,
  input  wire logic [17:0]            phaseEnergyTick,
  output logic [3:0]                  pulseOut,
  output logic [3:0]                  pulseConstSel,
  output logic                        reactiveSumMode,
  output logic                        activeSumMode,
  output logic                        energyReadClearMode,
  output logic                        neutralInVectorSum,
  output logic                        startupSourceSel,
  output logic [2:0]                  reactiveSignInvert,
  output logic [2:0]                  activeSignInvert,
  output logic [6:0]                  highpassBypass,
  output logic [17:0]                 meterEnable,
  output logic [17:0]                 accumTick
);
  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  if (ADDR_W < 7)
    $error("address too narrow for the register offsets");
  if (PHASES != 3)
    $error("field layout serves exactly three phases");

  // ----------------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------------
  logic rstSync1;
  logic rstSync2;
  logic rstN;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  assign rstN = rstSync2;

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  empc_pkg::empc_word_t pulseCfg;
  empc_pkg::empc_word_t meterCfg;
  empc_pkg::empc_word_t enableCtl;
  empc_pkg::empc_word_t wire3Keep;
  logic                 hitPulse;
  logic                 hitMeter;
  logic                 hitEnable;

  assign hitPulse  = regAddr == ADDR_W'(`EMPC_ADDR_PULSE_CFG);
  assign hitMeter  = regAddr == ADDR_W'(`EMPC_ADDR_METER_CFG);
  assign hitEnable = regAddr == ADDR_W'(`EMPC_ADDR_METER_EN);

  // Four-wire mode keeps the three-wire-only bits at zero
  assign wire3Keep = wiringModeSel ? 24'hFFFFFF : ~`EMPC_MCFG_WIRE3_MASK;

  // Reserved bits never store, so they read fixed values
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      pulseCfg <= `EMPC_PULSE_CFG_RESET;
    else if (regWrite && hitPulse)
      pulseCfg <= (regWrData & `EMPC_PULSE_CFG_WMASK) | `EMPC_PULSE_CFG_FIXED;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      meterCfg <= `EMPC_METER_CFG_RESET;
    else if (regWrite && hitMeter)
      meterCfg <= (regWrData & `EMPC_METER_CFG_WMASK & wire3Keep)
                  | `EMPC_METER_CFG_FIXED;
    else
      meterCfg <= meterCfg & wire3Keep;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      enableCtl <= `EMPC_METER_EN_RESET;
    else if (regWrite && hitEnable)
      enableCtl <= regWrData & `EMPC_METER_EN_WMASK;
  end

  // ----------------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      regRdData <= '0;
    else if (regRead)
    begin
      if (hitPulse)
        regRdData <= pulseCfg;
      else if (hitMeter)
        regRdData <= meterCfg;
      else if (hitEnable)
        regRdData <= enableCtl;
      else
        regRdData <= '0;
    end
    else
      regRdData <= '0;
  end

  // ----------------------------------------------------------------------------
  // Metering controls
  // ----------------------------------------------------------------------------
  assign reactiveSumMode     = meterCfg[`EMPC_MCFG_QSUM_BIT];
  assign activeSumMode       = meterCfg[`EMPC_MCFG_PSUM_BIT];
  assign energyReadClearMode = meterCfg[`EMPC_MCFG_ECUM_BIT];
  assign neutralInVectorSum  = meterCfg[`EMPC_MCFG_NSUM_BIT];
  assign startupSourceSel    = meterCfg[`EMPC_MCFG_START_BIT];
  assign reactiveSignInvert  = meterCfg[`EMPC_MCFG_QSIGN_LSB +: 3];
  assign activeSignInvert    = meterCfg[`EMPC_MCFG_PSIGN_LSB +: 3];
  assign highpassBypass      = meterCfg[`EMPC_MCFG_HPF_LSB +: 7];

  // ----------------------------------------------------------------------------
  // Pulse outputs and meter enables
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_pulse
    empc_pulse_route #(
      .ALT_ACTIVE (i == 0)
    ) u_route (
      .clock       (clock),
      .rstN        (rstN),
      .sourceSel   (pulseCfg[`EMPC_FIELD_STRIDE*i +: 3]),
      .energyPulse (energyPulse),
      .pulseOut    (pulseOut[i])
    );
    assign pulseConstSel[i] = pulseCfg[`EMPC_FIELD_STRIDE*i + `EMPC_CONST_SEL_OFS];
  end

  // Quantity order: active, reactive, apparent, then the three fundamentals
  for (genvar q = 0; q < 6; q++)
  begin : g_enable
    assign meterEnable[3*q +: 3] = enableCtl[`EMPC_FIELD_STRIDE*q +: 3];
  end

  // Power and RMS never pass here, so only accumulation is gated
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      accumTick <= '0;
    else
      accumTick <= phaseEnergyTick & meterEnable;
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  pulse_rsvd_a: assert property (
    regRead && hitPulse |=> regRdData[23:16] == {5'h00, `EMPC_PULSE_RSVD_VAL})
    else $error("pulse register reserved bits read wrong");
  meter_rsvd_a: assert property (
    regRead && hitMeter |=> regRdData[23:22] == `EMPC_MCFG_RSVD_VAL
                            && regRdData[17] == 1'b0 && regRdData[15] == 1'b0)
    else $error("metering register reserved bits read wrong");
  enable_rsvd_a: assert property (
    regRead && hitEnable |=> (regRdData & ~`EMPC_METER_EN_WMASK) == 24'h000000)
    else $error("enable register reserved bits not zero");
  pulse_write_a: assert property (
    regWrite && hitPulse ##1 regRead && hitPulse |=> regRdData[15:0] == $past(regWrData[15:0], 2))
    else $error("pulse fields do not hold written value");
  const_sel_a: assert property (
    regWrite && hitPulse |=> pulseConstSel == {$past(regWrData[15]), $past(regWrData[11]),
                                               $past(regWrData[7]), $past(regWrData[3])})
    else $error("pulse constant selects wrong");
  qsum_four_a: assert property (
    !wiringModeSel |=> !reactiveSumMode)
    else $error("reactive sum mode set in four-wire mode");
  psum_four_a: assert property (
    !wiringModeSel |=> !activeSumMode)
    else $error("active sum mode set in four-wire mode");
  nsum_four_a: assert property (
    !wiringModeSel |=> !neutralInVectorSum)
    else $error("neutral sum set in four-wire mode");
  wire3_write_a: assert property (
    regWrite && hitMeter && wiringModeSel ##1 wiringModeSel
    |-> {reactiveSumMode, activeSumMode, neutralInVectorSum}
        == {$past(regWrData[21]), $past(regWrData[20]), $past(regWrData[18])})
    else $error("three-wire mode bits not writable");
  mode_bits_a: assert property (
    regWrite && hitMeter |=> energyReadClearMode == $past(regWrData[19])
                             && startupSourceSel == $past(regWrData[16]))
    else $error("read mode or startup source not stored");
  sign_bits_a: assert property (
    regWrite && hitMeter |=> reactiveSignInvert == $past(regWrData[14:12])
                             && activeSignInvert == $past(regWrData[10:8]))
    else $error("sign invert bits not stored");
  hpf_bits_a: assert property (
    regWrite && hitMeter |=> highpassBypass == $past(regWrData[6:0]))
    else $error("filter bypass bits not stored");
  accum_gate_a: assert property (
    1'b1 |=> accumTick == $past(phaseEnergyTick & meterEnable))
    else $error("energy tick not gated by its enable");
  enable_map_a: assert property (
    regWrite && hitEnable |=> meterEnable[17:15] == $past(regWrData[22:20])
                              && meterEnable[2:0] == $past(regWrData[2:0]))
    else $error("enable fields mapped wrongly");
  idle_read_a: assert property (
    !regRead |=> regRdData == 24'h000000)
    else $error("read data outside read cycle");

  pulse_cfg_c: cover property (regWrite && hitPulse ##1 regRead && hitPulse);
  four_wire_c: cover property (regWrite && hitMeter && !wiringModeSel ##1 regRead && hitMeter);
  pulse_out_c: cover property (|pulseOut);
  accum_c:     cover property (|accumTick);
endmodule
`default_nettype wire

// ===== rtl/empc_defs.svh
// Register map, field layout and reset constants of the metering configuration bank
// ----------------------------------------------------------------------------
// Summary of operation
// - Source codes pick six energies; 111 silences
// - Output one bits 0-2, 110 is total active
// - Output two bits 4-6, resets reactive
// - Output three bits 8-10, resets apparent
// - Output four bits 12-14, fundamental active
// - Bits 3,7,11,15 pick pulse constant a/b
// - Bits 16-18 read 100, 19-23 reserved
// - Bit 21 reactive sum mode, four-wire forces 0
// - Bit 20 active sum mode, four-wire forces 0
// - Bit 19 clear-on-read or cumulative energy
// - Bit 18 neutral in sum, four-wire forces 0
// - Bit 16 startup compares total or fundamental
// - Bits 12-14 per-phase reactive sign invert
// - Bits 8-10 per-phase active sign invert
// - Bits 0-6 bypass channel high-pass filters
// - Bits 22-23 reserved, read 01
// - Bits 0-2 gate per-phase active energy
// - Enables gate energy only, not power
// - Five more per-phase enable fields, reset off
// ----------------------------------------------------------------------------
`ifndef EMPC_DEFS_SVH
`define EMPC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define EMPC_ADDR_PULSE_CFG   8'h60
`define EMPC_ADDR_METER_CFG   8'h61
`define EMPC_ADDR_METER_EN    8'h62

// ----------------------------------------------------------------------------
// Reset values, writable masks and fixed reserved contents
// ----------------------------------------------------------------------------
`define EMPC_PULSE_CFG_RESET  24'h043210
`define EMPC_PULSE_CFG_WMASK  24'h00FFFF
`define EMPC_PULSE_CFG_FIXED  24'h040000
`define EMPC_METER_CFG_RESET  24'h400000
`define EMPC_METER_CFG_WMASK  24'h3D777F
`define EMPC_METER_CFG_FIXED  24'h400000
`define EMPC_MCFG_WIRE3_MASK  24'h340000
`define EMPC_METER_EN_RESET   24'h000000
`define EMPC_METER_EN_WMASK   24'h777777

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EMPC_FIELD_STRIDE     4
`define EMPC_CONST_SEL_OFS    3
`define EMPC_PULSE_RSVD_LSB   16
`define EMPC_PULSE_RSVD_VAL   3'h4
`define EMPC_MCFG_RSVD_LSB    22
`define EMPC_MCFG_RSVD_VAL    2'h1
`define EMPC_MCFG_QSUM_BIT    21
`define EMPC_MCFG_PSUM_BIT    20
`define EMPC_MCFG_ECUM_BIT    19
`define EMPC_MCFG_NSUM_BIT    18
`define EMPC_MCFG_START_BIT   16
`define EMPC_MCFG_QSIGN_LSB   12
`define EMPC_MCFG_PSIGN_LSB   8
`define EMPC_MCFG_HPF_LSB     0

// ----------------------------------------------------------------------------
// Pulse source codes
// ----------------------------------------------------------------------------
`define EMPC_SRC_TOT_ACTIVE   3'h0
`define EMPC_SRC_LAST_ENERGY  3'h5
`define EMPC_SRC_ALT_ACTIVE   3'h6
`define EMPC_SRC_OFF          3'h7

`endif

// ===== rtl/empc_pkg.sv
// Shared types of the metering configuration bank
package empc_pkg;
  typedef logic [2:0]  empc_src_t;
  typedef logic [23:0] empc_word_t;
  typedef logic [5:0]  empc_energy_t;
endpackage

// ===== rtl/empc_pulse_route.sv
// One calibration pulse output: picks an energy pulse by its source code
`timescale 1ns/10ps
`default_nettype none
`include "empc_defs.svh"
module empc_pulse_route #(
  parameter bit ALT_ACTIVE = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  rstN,
  input  wire empc_pkg::empc_src_t    sourceSel,
  input  wire empc_pkg::empc_energy_t energyPulse,
  output logic                       pulseOut
);
  logic next_pulseOut;

  always_comb
  begin
    next_pulseOut = 1'b0;
    if (sourceSel <= `EMPC_SRC_LAST_ENERGY)
    begin
      next_pulseOut = energyPulse[sourceSel];
    end
    else if (ALT_ACTIVE && sourceSel == `EMPC_SRC_ALT_ACTIVE)
    begin
      next_pulseOut = energyPulse[0];
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      pulseOut <= 1'b0;
    else
      pulseOut <= next_pulseOut;
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  silent_code_a: assert property (@(posedge clock) disable iff (!rstN)
    sourceSel == `EMPC_SRC_OFF |=> !pulseOut)
    else $error("pulse seen on a silenced output");
  follow_code_a: assert property (@(posedge clock) disable iff (!rstN)
    sourceSel <= `EMPC_SRC_LAST_ENERGY |=> pulseOut == $past(energyPulse[sourceSel]))
    else $error("pulse output does not follow its source");
  alt_code_a: assert property (@(posedge clock) disable iff (!rstN)
    sourceSel == `EMPC_SRC_ALT_ACTIVE |=> pulseOut == (ALT_ACTIVE && $past(energyPulse[0])))
    else $error("code 110 handled wrongly");
endmodule
`default_nettype wire

// ===== tb/energy_meter_pulse_config_tb.sv
// Self-checking bench for the metering configuration bank
`timescale 1ns/10ps
`default_nettype none
module energy_meter_pulse_config_tb;
  // ----------------------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------------------
  logic                   clock;
  logic                   resetN;
  logic [7:0]             regAddr;
  empc_pkg::empc_word_t   regWrData;
  logic                   regWrite;
  logic                   regRead;
  empc_pkg::empc_word_t   regRdData;
  logic                   wiringModeSel;
  empc_pkg::empc_energy_t energyPulse;
  logic [17:0]            phaseEnergyTick;
  logic [3:0]             pulseOut;
  logic [3:0]             pulseConstSel;
  logic                   reactiveSumMode;
  logic                   activeSumMode;
  logic                   energyReadClearMode;
  logic                   neutralInVectorSum;
  logic                   startupSourceSel;
  logic [2:0]             reactiveSignInvert;
  logic [2:0]             activeSignInvert;
  logic [6:0]             highpassBypass;
  logic [17:0]            meterEnable;
  logic [17:0]            accumTick;
  int                     mismatches;
  int                     numChecks;
  int                     cycles;
  empc_pkg::empc_word_t   rdVal;
  logic [3:0]             expPulse;
  // Rows: address, write data, read-back expected (three-wire wiring)
  localparam logic [55:0] ROWS [8] = '{
    56'h60_FFFFFF_04FFFF, 56'h60_000000_040000, 56'h61_FFFFFF_7D777F,
    56'h61_000000_400000, 56'h62_FFFFFF_777777, 56'h62_000000_000000,
    56'h63_FFFFFF_000000, 56'h5F_FFFFFF_000000};

  empc_config_regs i_empc_config_regs (
    .clock               (clock),
    .reset_n             (resetN),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrite            (regWrite),
    .regRead             (regRead),
    .regRdData           (regRdData),
    .wiringModeSel       (wiringModeSel),
    .energyPulse         (energyPulse),
    .phaseEnergyTick     (phaseEnergyTick),
    .pulseOut            (pulseOut),
    .pulseConstSel       (pulseConstSel),
    .reactiveSumMode     (reactiveSumMode),
    .activeSumMode       (activeSumMode),
    .energyReadClearMode (energyReadClearMode),
    .neutralInVectorSum  (neutralInVectorSum),
    .startupSourceSel    (startupSourceSel),
    .reactiveSignInvert  (reactiveSignInvert),
    .activeSignInvert    (activeSignInvert),
    .highpassBypass      (highpassBypass),
    .meterEnable         (meterEnable),
    .accumTick           (accumTick)
  );

  always #10 clock = ~clock;

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input empc_pkg::empc_word_t seen, input empc_pkg::empc_word_t exp,
                     input string what);
    numChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic regWr(input logic [7:0] a, input empc_pkg::empc_word_t d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Data is only valid in the cycle after the strobe
  task automatic regRd(input logic [7:0] a, output empc_pkg::empc_word_t d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  // Write then read back in the very next cycle, no gap between strobes
  task automatic regWrRd(input logic [7:0] a, input empc_pkg::empc_word_t w,
                         output empc_pkg::empc_word_t d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= w;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic applyReset;
    resetN <= 1'b0;
    repeat (2) @(posedge clock);
    resetN <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic checkDefaults;
    regRd(8'h60, rdVal);
    chk(rdVal, 24'h043210, "pulse reg reset");
    regRd(8'h61, rdVal);
    chk(rdVal, 24'h400000, "meter cfg reset");
    regRd(8'h62, rdVal);
    chk(rdVal, 24'h000000, "enable reset");
    chk({20'h0, pulseConstSel}, 24'h0, "const sel reset");
    chk({14'h0, activeSignInvert, highpassBypass}, 24'h0, "sign and filter reset");
    chk({6'h0, meterEnable}, 24'h0, "meter enable reset");
  endtask

  function automatic logic [17:0] enMap(input empc_pkg::empc_word_t r);
    logic [17:0] e;
    for (int q = 0; q < 6; q++)
      for (int p = 0; p < 3; p++)
        e[3*q+p] = r[4*q+p];
    return e;
  endfunction

  // ----------------------------------------------------------------------------
  // Hang guard: whole run needs well under a thousand cycles
  // ----------------------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    resetN = 1'b0;
    regAddr = 8'h00;
    regWrData = 24'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    wiringModeSel = 1'b1;
    energyPulse = 6'h00;
    phaseEnergyTick = 18'h0;
    mismatches = 0;
    numChecks = 0;
    cycles = 0;
    applyReset();
    checkDefaults();
    $display("test reset values done");
    foreach (ROWS[i])
    begin
      regWrRd(ROWS[i][55:48], ROWS[i][47:24], rdVal);
      chk(rdVal, ROWS[i][23:0], "row read-back");
      @(posedge clock);
      #1 chk(regRdData, 24'h0, "read data stands once");
    end
    $display("test register table done");
    // Every code on all four outputs against every energy pulse
    for (int c = 0; c < 8; c++)
    begin
      regWr(8'h60, {8'h00, 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
      for (int k = 0; k < 6; k++)
      begin
        @(posedge clock);
        energyPulse <= 6'(1 << k);
        @(posedge clock);
        for (int o = 0; o < 4; o++)
          expPulse[o] = (c == k) || (o == 0 && c == 6 && k == 0);
        #1 chk({20'h0, pulseOut}, {20'h0, expPulse}, "pulse route");
      end
      @(posedge clock);
      energyPulse <= 6'h00;
    end
    $display("test pulse routing done");
    regWr(8'h60, 24'h00A5A5);
    #1 chk({20'h0, pulseConstSel}, 24'h00000A, "const sel");
    regWr(8'h61, 24'h3D5A55);
    regRd(8'h61, rdVal);
    chk(rdVal, 24'h7D5255, "meter cfg fields");
    chk({19'h0, reactiveSumMode, activeSumMode, energyReadClearMode, neutralInVectorSum,
         startupSourceSel}, 24'h1F, "mode bits");
    chk({18'h0, reactiveSignInvert, activeSignInvert}, 24'h2A, "sign invert");
    chk({17'h0, highpassBypass}, 24'h55, "filter bypass");
    @(posedge clock);
    wiringModeSel <= 1'b0;
    regRd(8'h61, rdVal);
    chk(rdVal, 24'h495255, "four-wire clears");
    chk({21'h0, reactiveSumMode, activeSumMode, neutralInVectorSum}, 24'h0, "four-wire out");
    regWrRd(8'h61, 24'hFFFFFF, rdVal);
    chk(rdVal, 24'h49777F, "four-wire write ignored");
    @(posedge clock);
    wiringModeSel <= 1'b1;
    $display("test metering modes done");
    regWr(8'h62, 24'h712345);
    #1 chk({6'h0, meterEnable}, {6'h0, enMap(24'h712345)}, "enable map");
    foreach (ROWS[i])
    begin
      @(posedge clock);
      phaseEnergyTick <= 18'(ROWS[i][17:0] ^ 18'h2AAAA);
      @(posedge clock);
      #1 chk({6'h0, accumTick}, {6'h0, (ROWS[i][17:0] ^ 18'h2AAAA) & enMap(24'h712345)},
             "tick gate");
    end
    $display("test meter enables done");
    applyReset();
    checkDefaults();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
